// File: dca_device.sv
// Device end: average-current and auto-zero message handling over the serial link.
// Assumes link pins are asynchronous; measurement side runs on SYS_CLK_I.
//
// What this block does
// - Identifier 0110 selects average read; bit31 write
// - Channel field selects reported channel, also max/min
// - Average response echoes header, flag bit20, sum
// - New flag set on result, cleared read/change
// - Bits 19:0 hold 20-bit dither summation
// - Fresh result at the second window end after change
// - Host checks summation overflow at 512 samples
// - Identifier 0111 selects auto-zero trigger or read
// - Gate-on flag bit17, gate-off flag bit16
// - Gate-on offset 15:8, gate-off offset 7:0
// - Write starts auto-zero and clears both flags
// - Flags set only when started sequence finishes
// - Read clears both flags, starts nothing
// - Host waits for current decay before trigger
// - Zero dither steps: window is one period
`timescale 1ns/1ps
`include "dca_consts.svh"
module dca_device #(
    parameter int NCH = 8
) (
    input  wire logic                SYS_CLK_I,
    input  wire logic                NRST_I,
    dca_spi_if.dev                   SPI,
    output      dca_pkg::dca_channel_select_t  CHANNEL_SELECT_SEL_O,
    input  wire logic                PWM_END_I,
    input  wire logic                DITHER_END_I,
    input  wire logic [4:0]          DITHER_STEPS_I,
    input  wire logic [19:0]         AVG_SUM_I,
    output      logic                AZ_START_O,
    output      dca_pkg::dca_channel_select_t  AZ_CHANNEL_SELECT_O,
    input  wire logic                AZ_ON_DONE_I,
    input  wire logic                AZ_OFF_DONE_I,
    input  wire dca_pkg::dca_channel_select_t  AZ_DONE_CHANNEL_SELECT_I,
    input  wire logic [7:0]          AZ_ON_VAL_I,
    input  wire logic [7:0]          AZ_OFF_VAL_I
);
    import dca_pkg::*;

    logic [2:0]  sck_q;
    logic [2:0]  csn_q;
    logic [1:0]  mosi_q;
    logic        sck_rise;
    logic        sck_fall;
    logic        csn_fall;
    logic        csn_rise;
    logic [31:0] rx_q;
    logic [31:0] tx_q;
    logic [5:0]  cnt_q;
    logic        exec;
    logic        cmd_wr;
    dca_msg_t    cmd_msg;
    dca_channel_select_t   cmd_ch;
    logic        pend_q;
    dca_msg_t    pmsg_q;
    dca_channel_select_t   pch_q;
    logic [31:0] resp;
    logic        ship_avg;
    logic        ship_az;
    dca_channel_select_t   sel_q;
    logic        sel_cmd;
    logic        chg;
    logic        discard_q;
    logic        win_end;
    logic        take;
    logic [19:0] sum_q;
    logic        new_q;
    logic        az_wr;
    logic        miso_q;
    logic        oe_n_q;
    logic [NCH-1:0] bon_q;
    logic [NCH-1:0] boff_q;
    logic [NCH-1:0] zon_q;
    logic [NCH-1:0] zoff_q;
    logic [7:0]  onv_q  [NCH];
    logic [7:0]  offv_q [NCH];

    // Pins are asynchronous; stage [0] feeds only stage [1]
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sck_q  <= 3'h0;
            csn_q  <= 3'h7;
            mosi_q <= 2'h0;
        end else begin
            sck_q  <= {sck_q[1:0], SPI.sclk};
            csn_q  <= {csn_q[1:0], SPI.csn};
            mosi_q <= {mosi_q[0], SPI.mosi};
        end
    end

    assign sck_rise = sck_q[1] & ~sck_q[2];
    assign sck_fall = ~sck_q[1] & sck_q[2];
    assign csn_fall = ~csn_q[1] & csn_q[2];
    assign csn_rise = csn_q[1] & ~csn_q[2];

    // Receive shifter; the count saturates at 63, so bits past 32 void the frame
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rx_q  <= 32'h0;
            cnt_q <= 6'h0;
        end else if (csn_fall) begin
            cnt_q <= 6'h0;
        end else if (sck_rise && !csn_q[1]) begin
            rx_q <= {rx_q[30:0], mosi_q[1]};
            if (cnt_q != 6'h3f) begin
                cnt_q <= cnt_q + 6'h1;
            end
        end
    end

    assign exec    = csn_rise && (cnt_q == `DCA_FRAME_BITS);
    assign cmd_wr  = rx_q[`DCA_RW_BIT];
    assign cmd_msg = rx_q[`DCA_MID_HI:`DCA_MID_LO];
    assign cmd_ch  = rx_q[`DCA_CH_HI:`DCA_CH_LO];

    // Command is answered in the next frame, then retired
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pend_q <= 1'b0;
            pmsg_q <= 4'h0;
            pch_q  <= 3'h0;
        end else if (exec) begin
            pend_q <= 1'b1;
            pmsg_q <= cmd_msg;
            pch_q  <= cmd_ch;
        end else if (csn_fall) begin
            pend_q <= 1'b0;
        end
    end

    assign ship_avg = csn_fall && pend_q && (pmsg_q == `DCA_MID_AVG);
    assign ship_az  = csn_fall && pend_q && (pmsg_q == `DCA_MID_AZ);

    always_comb begin
        resp = 32'h0;
        if (pend_q) begin
            resp[`DCA_MID_HI:`DCA_CH_LO] = {pmsg_q, pch_q};
            if (pmsg_q == `DCA_MID_AVG) begin
                resp[`DCA_AVG_NEW_BIT]     = new_q;
                resp[`DCA_AVG_SUM_HI:0]    = sum_q;
            end else if (pmsg_q == `DCA_MID_AZ) begin
                resp[`DCA_ZON_BIT]         = zon_q[pch_q];
                resp[`DCA_ZOFF_BIT]        = zoff_q[pch_q];
                resp[`DCA_ONV_HI:`DCA_ONV_LO]   = onv_q[pch_q];
                resp[`DCA_OFFV_HI:`DCA_OFFV_LO] = offv_q[pch_q];
            end
        end
    end

    // Transmit shifter; changes after falling clock so host samples a settled bit
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            tx_q <= 32'h0;
        end else if (csn_fall) begin
            tx_q <= resp;
        end else if (sck_fall && !csn_q[1]) begin
            tx_q <= {tx_q[30:0], 1'b0};
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            miso_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            miso_q <= tx_q[31];
            oe_n_q <= csn_q[1];
        end
    end

    assign SPI.miso_d    = miso_q;
    assign SPI.miso_oe_n = oe_n_q;

    // Channel selection shared with the max/min message
    assign sel_cmd = exec && ((cmd_msg == `DCA_MID_AVG) || (cmd_msg == `DCA_MID_MAXMIN));
    assign chg     = sel_cmd && (cmd_ch != sel_q);

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sel_q <= 3'h0;
        end else if (sel_cmd) begin
            sel_q <= cmd_ch;
        end
    end

    assign CHANNEL_SELECT_SEL_O = sel_q;

    // Undithered channel closes its window every PWM period
    assign win_end = (DITHER_STEPS_I == 5'h0) ? PWM_END_I : DITHER_END_I;

    // Window running at a change is partly old channel, so it is dropped
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            discard_q <= 1'b0;
        end else if (chg) begin
            discard_q <= 1'b1;
        end else if (win_end) begin
            discard_q <= 1'b0;
        end
    end

    assign take = win_end && !discard_q && !chg;

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sum_q <= 20'h0;
        end else if (take) begin
            sum_q <= AVG_SUM_I;
        end
    end

    // Fresh result beats a read clear in the same cycle
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            new_q <= 1'b0;
        end else if (take) begin
            new_q <= 1'b1;
        end else if (chg || ship_avg) begin
            new_q <= 1'b0;
        end
    end

    assign az_wr = exec && cmd_wr && (cmd_msg == `DCA_MID_AZ);

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            AZ_START_O <= 1'b0;
            AZ_CHANNEL_SELECT_O  <= 3'h0;
        end else begin
            AZ_START_O <= az_wr;
            if (az_wr) begin
                AZ_CHANNEL_SELECT_O <= cmd_ch;
            end
        end
    end

    // Per-channel busy, flags and offsets
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            bon_q  <= '0;
            boff_q <= '0;
            zon_q  <= '0;
            zoff_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                onv_q[i]  <= 8'h0;
                offv_q[i] <= 8'h0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (az_wr && (cmd_ch == i[2:0])) begin
                    bon_q[i]  <= 1'b1;
                    boff_q[i] <= 1'b1;
                    zon_q[i]  <= 1'b0;
                    zoff_q[i] <= 1'b0;
                end else begin
                    if (AZ_ON_DONE_I && (AZ_DONE_CHANNEL_SELECT_I == i[2:0])) begin
                        bon_q[i] <= 1'b0;
                    end
                    if (AZ_OFF_DONE_I && (AZ_DONE_CHANNEL_SELECT_I == i[2:0])) begin
                        boff_q[i] <= 1'b0;
                    end
                    // Completion only counts for a sequence this block started
                    if (AZ_ON_DONE_I && (AZ_DONE_CHANNEL_SELECT_I == i[2:0]) && bon_q[i]) begin
                        zon_q[i] <= 1'b1;
                        onv_q[i] <= AZ_ON_VAL_I;
                    end else if (ship_az && (pch_q == i[2:0])) begin
                        zon_q[i] <= 1'b0;
                    end
                    if (AZ_OFF_DONE_I && (AZ_DONE_CHANNEL_SELECT_I == i[2:0]) && boff_q[i]) begin
                        zoff_q[i]  <= 1'b1;
                        offv_q[i]  <= AZ_OFF_VAL_I;
                    end else if (ship_az && (pch_q == i[2:0])) begin
                        zoff_q[i] <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

// File: dca_consts.svh
// Message layout, register offsets and timing counts for the command link.
// Assumes a 32-bit frame, most significant bit first.
`ifndef DCA_CONSTS_SVH
`define DCA_CONSTS_SVH
`define DCA_FRAME_BITS      6'h20
`define DCA_RW_BIT          31
`define DCA_MID_HI          30
`define DCA_MID_LO          27
`define DCA_CH_HI           26
`define DCA_CH_LO           24
`define DCA_MID_MAXMIN      4'h5
`define DCA_MID_AVG         4'h6
`define DCA_MID_AZ          4'h7
`define DCA_AVG_NEW_BIT     20
`define DCA_AVG_SUM_HI      19
`define DCA_ZON_BIT         17
`define DCA_ZOFF_BIT        16
`define DCA_ONV_HI          15
`define DCA_ONV_LO          8
`define DCA_OFFV_HI         7
`define DCA_OFFV_LO         0
`define DCA_OFS_CMD         8'h00
`define DCA_OFS_RESP        8'h04
`define DCA_OFS_STAT        8'h08
`define DCA_OFS_IRQ_STAT    8'h0c
`define DCA_OFS_IRQ_MASK    8'h10
`define DCA_IRQ_DONE        0
`define DCA_IRQ_NEWAVG      1
`define DCA_IRQ_AZ          2
`define DCA_CLK_PERIOD_NS   4
`define DCA_SCLK_HALF_NS    64
`define DCA_SCLK_HALF_CYC   ((`DCA_SCLK_HALF_NS + `DCA_CLK_PERIOD_NS - 1) / `DCA_CLK_PERIOD_NS)
`endif

// File: dca_pkg.sv
// Types shared by both ends of the command link.
// Assumes dca_consts.svh for all numeric constants.
package dca_pkg;
    typedef logic [3:0] dca_msg_t;
    typedef logic [2:0] dca_channel_select_t;
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_LOW  = 3'b001,
        H_HIGH = 3'b010,
        H_GAP  = 3'b011
    } dca_hstate_t;
endpackage

// File: dca_spi_if.sv
// Four-wire serial link between controller and device.
// Assumes a pull-up on the data-out wire while the device releases it.
`timescale 1ns/1ps
interface dca_spi_if;
    logic sclk;
    logic csn;
    logic mosi;
    logic miso_d;
    logic miso_oe_n;
    logic miso;
    assign miso = miso_oe_n ? 1'b1 : miso_d;
    modport host (output sclk, output csn, output mosi, input miso);
    modport dev  (input sclk, input csn, input mosi, output miso_d, output miso_oe_n);
endinterface

// File: dca_host.sv
// Controller end: APB registers drive one 32-bit frame per command write made while idle.
// Assumes APB master on SYS_CLK_I; the device pin is asynchronous.
`timescale 1ns/1ps
`include "dca_consts.svh"
module dca_host #(
    parameter int HALF = `DCA_SCLK_HALF_CYC
) (
    input  wire logic        SYS_CLK_I,
    input  wire logic        NRST_I,
    dca_spi_if.host          SPI,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output      logic [31:0] PRDATA_O,
    output      logic        PREADY_O,
    output      logic        PSLVERR_O,
    output      logic        IRQ_O
);
    import dca_pkg::*;

    dca_hstate_t st_q;
    logic [7:0]  div_q;
    logic [4:0]  bit_q;
    logic [31:0] cmd_q;
    logic [31:0] sh_q;
    logic [31:0] rx_q;
    logic [31:0] resp_q;
    logic [1:0]  miso_q;
    logic [2:0]  ist_q;
    logic [2:0]  imask_q;
    logic        hit;
    logic        wr;
    logic        start;
    logic        tick;
    logic        done;
    logic [2:0]  ev;

    assign hit = (PADDR_I == `DCA_OFS_CMD) || (PADDR_I == `DCA_OFS_RESP) || (PADDR_I == `DCA_OFS_STAT)
              || (PADDR_I == `DCA_OFS_IRQ_STAT) || (PADDR_I == `DCA_OFS_IRQ_MASK);
    assign PREADY_O  = PSEL_I & PENABLE_I;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
    assign wr    = PSEL_I & PENABLE_I & PWRITE_I;
    // Command written while a frame runs is dropped
    assign start = wr && (PADDR_I == `DCA_OFS_CMD) && (st_q == H_IDLE);
    assign tick  = (div_q == 8'(HALF - 1));
    assign done  = (st_q == H_GAP) && tick;

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PRDATA_O <= 32'h0;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            unique case (PADDR_I)
                `DCA_OFS_CMD:      PRDATA_O <= cmd_q;
                `DCA_OFS_RESP:     PRDATA_O <= resp_q;
                `DCA_OFS_STAT:     PRDATA_O <= {31'h0, st_q != H_IDLE};
                `DCA_OFS_IRQ_STAT: PRDATA_O <= {29'h0, ist_q};
                `DCA_OFS_IRQ_MASK: PRDATA_O <= {29'h0, imask_q};
                default:           PRDATA_O <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            miso_q <= 2'h3;
        end else begin
            miso_q <= {miso_q[0], SPI.miso};
        end
    end

    // Frame engine: data set while clock low, sampled at the rising edge
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_q     <= H_IDLE;
            div_q    <= 8'h0;
            bit_q    <= 5'h0;
            cmd_q    <= 32'h0;
            sh_q     <= 32'h0;
            rx_q     <= 32'h0;
            resp_q   <= 32'h0;
            SPI.sclk <= 1'b0;
            SPI.csn  <= 1'b1;
            SPI.mosi <= 1'b0;
        end else begin
            div_q <= (st_q == H_IDLE || tick) ? 8'h0 : div_q + 8'h1;
            unique case (st_q)
                H_IDLE: if (start) begin
                    cmd_q    <= PWDATA_I;
                    sh_q     <= PWDATA_I;
                    SPI.mosi <= PWDATA_I[31];
                    SPI.csn  <= 1'b0;
                    bit_q    <= 5'h0;
                    st_q     <= H_LOW;
                end
                H_LOW: if (tick) begin
                    rx_q     <= {rx_q[30:0], miso_q[1]};
                    SPI.sclk <= 1'b1;
                    st_q     <= H_HIGH;
                end
                H_HIGH: if (tick) begin
                    SPI.sclk <= 1'b0;
                    sh_q     <= {sh_q[30:0], 1'b0};
                    SPI.mosi <= sh_q[30];
                    bit_q    <= bit_q + 5'h1;
                    if (bit_q == 5'h1f) begin
                        SPI.csn <= 1'b1;
                        resp_q  <= rx_q;
                        st_q    <= H_GAP;
                    end else begin
                        st_q <= H_LOW;
                    end
                end
                H_GAP: if (tick) begin
                    st_q <= H_IDLE;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end

    assign ev[`DCA_IRQ_DONE]   = done;
    assign ev[`DCA_IRQ_NEWAVG] = done && (resp_q[`DCA_MID_HI:`DCA_MID_LO] == `DCA_MID_AVG)
                                 && resp_q[`DCA_AVG_NEW_BIT];
    assign ev[`DCA_IRQ_AZ]     = done && (resp_q[`DCA_MID_HI:`DCA_MID_LO] == `DCA_MID_AZ)
                                 && (resp_q[`DCA_ZON_BIT] || resp_q[`DCA_ZOFF_BIT]);

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ist_q   <= 3'h0;
            imask_q <= 3'h0;
        end else begin
            if (wr && PADDR_I == `DCA_OFS_IRQ_STAT) begin
                ist_q <= (ist_q & ~PWDATA_I[2:0]) | ev;
            end else begin
                ist_q <= ist_q | ev;
            end
            if (wr && PADDR_I == `DCA_OFS_IRQ_MASK) begin
                imask_q <= PWDATA_I[2:0];
            end
        end
    end

    assign IRQ_O = |(ist_q & imask_q);
endmodule

// File: dca_props.sv
// Checker for the serial link between the two ends.
// Assumes the bench ties it to the link interface and hands on the host's HALF.
`timescale 1ns/1ps
module dca_props #(
    parameter int HALF = 16
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire logic sclk,
    input wire logic csn,
    input wire logic mosi,
    input wire logic miso_d,
    input wire logic miso_oe_n,
    input wire logic miso
);
    logic [5:0] rise_q;
    logic [7:0] hi_q;
    logic [7:0] gap_q;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I)               rise_q <= 6'h00;
        else if (csn)              rise_q <= 6'h00;
        else if ($rose(sclk))      rise_q <= rise_q + 6'h01;
    end
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I)               hi_q <= 8'h00;
        else if (sclk)             hi_q <= hi_q + 8'h01;
        else                       hi_q <= 8'h00;
    end
    // Saturates so a long idle never wraps below the gap bound
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I)               gap_q <= 8'hff;
        else if (!csn)             gap_q <= 8'h00;
        else if (gap_q != 8'hff)   gap_q <= gap_q + 8'h01;
    end
    sequence s_low4;
        !sclk [*4];
    endsequence
    sequence s_first_rise;
        $rose(sclk) && !csn && (rise_q == 6'h00);
    endsequence
    a_sclk_idle_low:  assert property (csn && $past(csn) |-> !sclk)
        else $error("sclk high outside a frame");
    a_frame_low_start: assert property ($fell(csn) |-> s_low4)
        else $error("frame starts without low phase");
    a_high_phase_len: assert property ($fell(sclk) |-> hi_q == HALF)
        else $error("sclk high phase length wrong");
    a_mosi_hold:      assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    a_frame_bits:     assert property ($rose(csn) |-> rise_q == 6'h20)
        else $error("frame not 32 bits");
    a_frame_gap:      assert property ($fell(csn) |-> gap_q >= HALF)
        else $error("gap between frames too short");
    a_resp_msb_low:   assert property (s_first_rise |-> !miso_oe_n && !miso_d)
        else $error("response bit 31 not driven low");
    a_miso_released:  assert property (csn [*8] |-> miso_oe_n && miso)
        else $error("device drives data-out while deselected");
    a_drive_in_frame: assert property ($rose(sclk) && !csn |-> !miso_oe_n)
        else $error("device not driving data-out in frame");
endmodule

// File: tb_dither_current_autozero_msgs.sv
// Bench joining host and device ends over the link; APB drives the host.
// Assumes HALF=8 to keep frames short; device measurement inputs come from here.
`timescale 1ns/1ps
module tb_dither_current_autozero_msgs;
    import dca_pkg::*;
    logic        clk = 1'b0, nrst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq, az_start;
    dca_channel_select_t   channel_select_sel, az_channel_select, done_ch = 3'h0;
    logic        pwm_end = 1'b0, dith_end = 1'b0, on_done = 1'b0, off_done = 1'b0;
    logic [4:0]  steps = 5'h05;
    logic [19:0] avg_sum = 20'h0, s1, s2, s3;
    logic [7:0]  on_val = 8'h00, off_val = 8'h00, von, voff;
    logic [32:0] rq[$];
    logic [7:0]  aq[$];
    int          failures = 0, comparisons = 0, seed = 96086;
    always #2 clk = ~clk;
    dca_spi_if spi();
    dca_host #(.HALF(8)) u_dca_host(.SYS_CLK_I(clk), .NRST_I(nrst), .SPI(spi), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq));
    dca_device #(.NCH(8)) u_dca_device(.SYS_CLK_I(clk), .NRST_I(nrst), .SPI(spi), .CHANNEL_SELECT_SEL_O(channel_select_sel),
        .PWM_END_I(pwm_end), .DITHER_END_I(dith_end), .DITHER_STEPS_I(steps), .AVG_SUM_I(avg_sum),
        .AZ_START_O(az_start), .AZ_CHANNEL_SELECT_O(az_channel_select), .AZ_ON_DONE_I(on_done), .AZ_OFF_DONE_I(off_done),
        .AZ_DONE_CHANNEL_SELECT_I(done_ch), .AZ_ON_VAL_I(on_val), .AZ_OFF_VAL_I(off_val));
    dca_props #(.HALF(8)) u_dca_props(.SYS_CLK_I(clk), .NRST_I(nrst), .sclk(spi.sclk), .csn(spi.csn),
        .mosi(spi.mosi), .miso_d(spi.miso_d), .miso_oe_n(spi.miso_oe_n), .miso(spi.miso));
    task report_and_stop;
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk_rd(input string n, input logic [32:0] e, input logic [32:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_sig(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Read results and start pulses are judged as they appear
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite)
            chk_rd("apb_read", (rq.size() > 0) ? rq.pop_front() : 33'h1ffffffff, {pslverr, prdata});
        if (az_start === 1'b1)
            chk_sig("az_channel_select", (aq.size() > 0) ? aq.pop_front() : 8'hff, {5'h00, az_channel_select});
    end
    // No cycle limit, the watchdog ends a hang; idle edge keeps calls apart
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk);
        while (pready !== 1'b1);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // One command frame; er is the answer to the previous command
    task xfer(input logic [31:0] c, input logic [31:0] er);
        logic [2:0] ib;
        ib = {er[30:27] == 4'h7 && (er[17] || er[16]), er[30:27] == 4'h6 && er[20], 1'b1};
        apb(1'b1, 8'h00, c);
        while (irq !== 1'b1) @(posedge clk);
        rd(8'h0c, {30'h0, ib});
        rd(8'h04, {1'b0, er});
        rd(8'h00, {1'b0, c});
        apb(1'b1, 8'h0c, 32'h1);
        @(posedge clk);
        chk_sig("irq_masked", 8'h00, {7'h00, irq});
        apb(1'b1, 8'h0c, 32'h7);
    endtask
    task win(input logic pwm, input logic [19:0] s);
        dith_end <= !pwm; pwm_end <= pwm; avg_sum <= s;
        @(posedge clk);
        dith_end <= 1'b0; pwm_end <= 1'b0; avg_sum <= $random(seed);
        repeat (4) @(posedge clk);
    endtask
    task azd(input logic on, input dca_channel_select_t ch, input logic [7:0] v);
        on_done <= on; off_done <= !on; done_ch <= ch; on_val <= v; off_val <= v;
        @(posedge clk);
        on_done <= 1'b0; off_done <= 1'b0; on_val <= $random(seed); off_val <= $random(seed);
        repeat (4) @(posedge clk);
    endtask
    initial begin
        s1 = $random(seed); s2 = $random(seed); s3 = $random(seed); von = $random(seed); voff = $random(seed);
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(8'h08, 33'h0); rd(8'h0c, 33'h0); rd(8'h04, 33'h0);
        rd(8'h14, 33'h100000000);
        apb(1'b1, 8'h10, 32'h5);
        rd(8'h10, 33'h5);
        apb(1'b1, 8'h10, 32'h1);
        xfer({1'b0, 4'h6, 3'h3, 24'h0}, 32'h0);
        chk_sig("channel_select_sel", 8'h03, {5'h00, channel_select_sel});
        win(1'b0, s1); win(1'b1, ~s2); win(1'b0, s2);
        xfer({1'b0, 4'h6, 3'h3, 24'h0}, {8'h33, 3'h0, 1'b1, s2});
        steps <= 5'h00;
        win(1'b1, s3);
        xfer({1'b0, 4'h6, 3'h3, 24'h0}, {8'h33, 3'h0, 1'b1, s3});
        aq.push_back(8'h05);
        xfer({1'b1, 4'h7, 3'h5, 24'h0}, {8'h33, 3'h0, 1'b0, s3});
        azd(1'b1, 3'h5, von); azd(1'b0, 3'h5, voff); azd(1'b1, 3'h2, 8'h5a);
        xfer({1'b0, 4'h7, 3'h5, 24'h0}, {8'h3d, 6'h0, 2'h3, von, voff});
        xfer({1'b0, 4'h7, 3'h2, 24'h0}, {8'h3d, 6'h0, 2'h0, von, voff});
        xfer({1'b0, 4'h5, 3'h6, 24'h0}, {8'h3a, 24'h0});
        chk_sig("channel_select_sel", 8'h06, {5'h00, channel_select_sel});
        xfer({1'b1, 4'h3, 3'h1, 24'h0}, {8'h2e, 24'h0});
        xfer({1'b0, 4'h6, 3'h6, 24'h0}, {8'h19, 24'h0});
        chk_sig("az_left", 8'h00, 8'(aq.size()));
        report_and_stop;
    end
    initial begin
        #400000;
        failures++;
        report_and_stop;
    end
endmodule
